//--- verif/auto_retry_ack_assertions.sv
// Purpose: concurrent checks on ack, seed and limit ports
// Assumes: one clock domain, async active-low reset
// Notes:   bound to the register block below the module
`timescale 1ns/1ps

module auto_retry_ack_assertions (
  input wire logic        clk,              // block clock
  input wire logic        arst_n,           // async reset, active low
  input wire logic        ackRequest,       // ack wanted
  input wire logic        ackSend_q,        // ack goes out
  input wire logic        ackWaiting_q,     // ack held
  input wire logic [2:0]  accessRetryLimit, // access limit
  input wire logic        immediateTx_q,    // skip access
  input wire logic        wakeDeep,         // wake pulse
  input wire logic        seedLoad_q,       // seed reload
  input wire logic [10:0] backoffSeed_q     // active seed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // a fresh request that the slot bit holds back
  sequence heldReq;
    ackRequest && !ackWaiting_q ##1 ackWaiting_q;
  endsequence

  chk_ack_either: assert property (
    ackRequest && !ackWaiting_q |=> ackSend_q ^ ackWaiting_q)
    else $error("ack neither sent nor held");
  chk_ack_held: assert property (
    heldReq |-> !ackSend_q)
    else $error("held ack was sent");
  chk_ack_release: assert property (
    $fell(ackWaiting_q) |-> ackSend_q)
    else $error("released ack not sent");
  chk_send_cause: assert property (
    ackSend_q |-> $past(ackRequest) || $past(ackWaiting_q))
    else $error("ack sent without cause");
  chk_immediate_tx: assert property (
    immediateTx_q == (accessRetryLimit == 3'h7))
    else $error("immediate flag wrong");
  chk_seed_load: assert property (
    wakeDeep |=> seedLoad_q)
    else $error("no reload after wake");
  chk_load_cause: assert property (
    seedLoad_q |-> $past(wakeDeep))
    else $error("reload without wake");
  chk_seed_hold: assert property (
    !seedLoad_q |-> $stable(backoffSeed_q))
    else $error("seed moved without reload");
endmodule : auto_retry_ack_assertions

bind auto_retry_ack_control_regs auto_retry_ack_assertions chk_i (
  .clk, .arst_n, .ackRequest, .ackSend_q, .ackWaiting_q,
  .accessRetryLimit, .immediateTx_q, .wakeDeep, .seedLoad_q,
  .backoffSeed_q);

//--- verif/host_model.sv
// Purpose: host driving the serial port and the trigger pin
// Assumes: mode 0, serial clock of eight block clocks
// Notes:   pins change by non-blocking assignment at clk rise
`timescale 1ns/1ps

module host_model (
  input  wire logic clk,           // block clock
  input  wire logic spiMiso,       // data from device
  input  wire logic spiMisoOe,     // device drives data out
  output logic      spiSclk,       // serial clock
  output logic      spiCsN,        // select, active low
  output logic      spiMosi,       // data to device
  output logic      sleepTxTrigger // ack trigger pin
);
  initial begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
    sleepTxTrigger = 1'b0;
  end

  // one frame: command then data, msb first; clock idle low
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    @(posedge clk) spiCsN <= 1'b0;
    // eight block clocks per bit: four low, four high
    for (int i = 15; i >= 0; i--) begin
      spiMosi <= sh[i];
      spiSclk <= 1'b0;
      repeat (4) @(posedge clk);
      spiSclk <= 1'b1;
      repeat (2) @(posedge clk);
      // an undriven data line reads as the inverse of the last bit
      if (i < 8) rd[i] = spiMisoOe ? spiMiso : ~spiMiso;
      repeat (2) @(posedge clk);
    end
    spiSclk <= 1'b0;
    repeat (4) @(posedge clk);
    spiCsN <= 1'b1;
    spiMosi <= ~spiMosi; // released line shows no stale bit
    repeat (6) @(posedge clk);
  endtask : xfer

  // rising edge releases a held ack
  task automatic trig(input logic v);
    @(posedge clk) sleepTxTrigger <= v;
  endtask : trig
endmodule : host_model

//--- verif/tb.sv
// Purpose: self-checking bench of the retry and ack registers
// Assumes: host model speaks the serial port
// Notes:   expectations come from the register map
`timescale 1ns/1ps
`include "auto_retry_ack_cfg.svh"

module tb;
  logic clk = 1'b0, arst_n = 1'b0, transactionStart = 1'b0;
  logic newBackoffCycle = 1'b0, newFrameCycle = 1'b0;
  logic ackRequest = 1'b0, wakeDeep = 1'b0;
  logic [2:0] coreResult = 3'h5;
  logic [4:0] coreState = 5'h0A;
  logic spiSclk, spiCsN, spiMosi, sleepTxTrigger, spiMiso_q;
  logic spiMisoOe_q, immediateTx_q, seedLoad_q, ackSend_q;
  logic ackWaiting_q;
  logic [3:0] frameRetryLimit;
  logic [2:0] accessRetryLimit;
  logic [10:0] backoffSeed_q;
  int err_count = 0, checked = 0;

  always #25 clk = ~clk;

  auto_retry_ack_control_regs auto_retry_ack_control_regs_i (.clk,
    .arst_n, .spiSclk, .spiCsN, .spiMosi, .spiMiso_q, .spiMisoOe_q,
    .sleepTxTrigger, .transactionStart, .newBackoffCycle, .newFrameCycle,
    .coreResult, .coreState, .ackRequest, .wakeDeep, .frameRetryLimit,
    .accessRetryLimit, .immediateTx_q, .backoffSeed_q, .seedLoad_q,
    .ackSend_q, .ackWaiting_q);
  host_model host_model_i (.clk, .spiMiso(spiMiso_q),
    .spiMisoOe(spiMisoOe_q), .spiSclk, .spiCsN, .spiMosi,
    .sleepTxTrigger);

  // compare and count
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_model_i.xfer({2'b10, a}, d, r);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    host_model_i.xfer({2'b00, a}, 8'h00, r);
    chk("register", {3'h0, e}, {3'h0, r});
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the expected run
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(6'h19, 8'h00);
    rd(6'h2C, 8'h38);
    rd(6'h2D, 8'hEA);
    chk("seed", 11'h2EA, backoffSeed_q);
    rd(6'h3F, 8'h00);
    $display("test reset done");
    @(posedge clk) newBackoffCycle <= 1'b1;
    repeat (6) @(posedge clk);
    newBackoffCycle <= 1'b0;
    rd(6'h19, 8'h0A);
    wr(6'h19, 8'hFF);
    rd(6'h19, 8'h0A);
    @(posedge clk) newFrameCycle <= 1'b1;
    @(posedge clk) newFrameCycle <= 1'b0;
    rd(6'h19, 8'h10);
    @(posedge clk) newFrameCycle <= 1'b1;
    repeat (16) @(posedge clk);
    newFrameCycle <= 1'b0;
    rd(6'h19, 8'hF0);
    @(posedge clk) transactionStart <= 1'b1;
    @(posedge clk) transactionStart <= 1'b0;
    rd(6'h19, 8'h00);
    $display("test counters done");
    for (int a = 0; a < 8; a++) begin
      if (a == 6) continue;
      wr(6'h2C, {4'(a), 3'(a), 1'b0});
      chk("frameLimit", 11'(a), {7'h0, frameRetryLimit});
      chk("accessLimit", 11'(a), {8'h0, accessRetryLimit});
      chk("immediate", {10'h0, a == 7}, {10'h0, immediateTx_q});
    end
    $display("test limits done");
    @(posedge clk) ackRequest <= 1'b1;
    @(posedge clk) ackRequest <= 1'b0;
    #1;
    chk("ackSend", 11'h1, {10'h0, ackSend_q});
    wr(6'h2C, 8'h39);
    @(posedge clk) ackRequest <= 1'b1;
    @(posedge clk) ackRequest <= 1'b0;
    @(posedge clk);
    #1;
    chk("ackWaiting", 11'h1, {10'h0, ackWaiting_q});
    rd(6'h02, {`ARA_AWAIT_ACK_CODE, 5'h0A});
    chk("ackSend", 11'h0, {10'h0, ackSend_q});
    host_model_i.trig(1'b1);
    for (int n = 0; n < 12 && ackSend_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("ackSend", 11'h1, {10'h0, ackSend_q});
    chk("ackWaiting", 11'h0, {10'h0, ackWaiting_q});
    host_model_i.trig(1'b0);
    rd(6'h02, 8'hAA);
    $display("test ack done");
    wr(6'h2D, 8'h5B);
    rd(6'h2D, 8'h5B);
    chk("seed", 11'h2EA, backoffSeed_q);
    @(posedge clk) wakeDeep <= 1'b1;
    @(posedge clk) wakeDeep <= 1'b0;
    #1;
    chk("seedLoad", 11'h1, {10'h0, seedLoad_q});
    chk("seed", 11'h25B, backoffSeed_q);
    wr(6'h2E, 8'hFD);
    rd(6'h2E, 8'h05);
    @(posedge clk) wakeDeep <= 1'b1;
    @(posedge clk) wakeDeep <= 1'b0;
    #1;
    chk("seed", 11'h55B, backoffSeed_q);
    $display("test seed done");
    end_of_test();
  end
endmodule : tb

//--- verilog/auto_retry_ack_cfg.svh
// Purpose: offsets, field positions, reset values and codes of the
//          extended-mode retry and acknowledgement registers
// Assumes: 6-bit register addresses on the serial register port
// Notes:   definitions only
`ifndef AUTO_RETRY_ACK_CFG_SVH
`define AUTO_RETRY_ACK_CFG_SVH

// register addresses
`define ARA_ADDR_STATE        6'h02
`define ARA_ADDR_RETRY_STATUS 6'h19
`define ARA_ADDR_LIMIT_CTRL   6'h2C
`define ARA_ADDR_SEED_LOW     6'h2D
`define ARA_ADDR_SEED_HIGH    6'h2E

// reset values
`define ARA_LIMIT_CTRL_RST    8'h38
`define ARA_SEED_LOW_RST      8'hEA
`define ARA_SEED_HIGH_RST     3'h2

// field positions
`define ARA_FRAME_MSB         7
`define ARA_FRAME_LSB         4
`define ARA_ACCESS_MSB        3
`define ARA_ACCESS_LSB        1
`define ARA_SLOT_BIT          0

// counter limits and codes
`define ARA_FRAME_CNT_MAX     4'hF
`define ARA_ACCESS_CNT_MAX    3'h5
`define ARA_ACCESS_IMMEDIATE  3'h7
`define ARA_AWAIT_ACK_CODE    3'h1

// serial frame layout
`define ARA_CMD_WRITE_BIT     7
`define ARA_CMD_LAST_BIT      5'h07
`define ARA_DATA_LAST_BIT     5'h0F
`define ARA_FRAME_BITS        5'h10

`endif

//--- verilog/auto_retry_ack_control_regs.sv
// Purpose: extended-mode retry counters, retry limits, slotted
//          acknowledgement hold and backoff seed registers
// Assumes: serial port mode 0, msb first; command byte then data byte
// Notes:   pins pass two flip-flops before use
// Functional notes
// - frame retry count reads in bits 7:4 of the status register, 0 at reset.
// - access retry count reads in bits 3:1, saturates at 5, bit 0 zero.
// - a new backoff cycle counts the access counter; a new frame cycle counts the frame counter and clears the access one.
// - bits 7:4 of the limit register give frame retransmissions, reset 3.
// - bits 3:1 give channel access retries, reset 4, host avoids six.
// - an access limit of 7 means immediate transmit without retries.
// - with the slot bit clear an acknowledgement goes out on its own.
// - with the slot bit set an acknowledgement is held for the host.
// - while held, the state register result field shows the wait code.
// - the low seed register is read-write and resets to 0xEA.
// - the 11-bit seed joins the high seed bits and the low seed byte.
// - the backoff seed is reloaded on each wake from deepest power-down.
`timescale 1ns/1ps
`include "auto_retry_ack_cfg.svh"

module auto_retry_ack_control_regs (
  input  wire logic        clk,              // 20 MHz block clock
  input  wire logic        arst_n,           // async reset, active low
  input  wire logic        spiSclk,          // serial clock pin
  input  wire logic        spiCsN,           // serial select, active low
  input  wire logic        spiMosi,          // serial data in
  output logic             spiMiso_q,        // serial data out
  output logic             spiMisoOe_q,      // data out enable
  input  wire logic        sleepTxTrigger,   // host trigger pin
  input  wire logic        transactionStart, // new retry transaction
  input  wire logic        newBackoffCycle,  // clear channel backoff start
  input  wire logic        newFrameCycle,    // retransmission start
  input  wire logic [2:0]  coreResult,       // result from core
  input  wire logic [4:0]  coreState,        // state from core
  input  wire logic        ackRequest,       // frame asks for an ack
  input  wire logic        wakeDeep,         // wake from deep power-down
  output logic [3:0]       frameRetryLimit,  // frame retry limit
  output logic [2:0]       accessRetryLimit, // access retry limit
  output logic             immediateTx_q,    // skip channel access
  output logic [10:0]      backoffSeed_q,    // active backoff seed
  output logic             seedLoad_q,       // seed reload pulse
  output logic             ackSend_q,        // send ack pulse
  output logic             ackWaiting_q      // ack held for trigger
);

  logic [3:0]  pins;
  logic        sclkS, csnS, mosiS, trigS;
  logic        sclkPrev_q, trigPrev_q;
  logic        sclkRise, sclkFall, trigRise;
  logic [4:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  rxShift_q, rxShift_d, rxNext;
  logic [7:0]  txShift_q, txShift_d;
  logic [5:0]  addr_q, addr_d;
  logic        isWrite_q, isWrite_d;
  logic        miso_d, misoOe_d;
  logic        doWrite;
  logic [7:0]  limit_q, limit_d;
  logic [7:0]  seedLow_q, seedLow_d;
  logic [2:0]  seedHigh_q, seedHigh_d;
  logic [3:0]  frameCnt_q, frameCnt_d;
  logic [2:0]  accessCnt_q, accessCnt_d;
  logic        immediateTx_d, seedLoad_d;
  logic [10:0] backoffSeed_d;
  logic        ackSend_d, ackWaiting_d;
  auto_retry_ack_pkg::ack_state_t ackState_q, ackState_d;

  // pin synchronisers; select idles high
  sync_two_ff #(
    .WIDTH (4),
    .RST   (4'h2)
  ) u_pins (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({sleepTxTrigger, spiMosi, spiCsN, spiSclk}),
    .q      (pins)
  );

  assign sclkS = pins[0];
  assign csnS  = pins[1];
  assign mosiS = pins[2];
  assign trigS = pins[3];

  // edge detection on synchronised pins
  assign sclkRise = sclkS & ~sclkPrev_q;
  assign sclkFall = ~sclkS & sclkPrev_q;
  assign trigRise = trigS & ~trigPrev_q;
  assign rxNext   = {rxShift_q[6:0], mosiS};

  assign frameRetryLimit  = limit_q[`ARA_FRAME_MSB:`ARA_FRAME_LSB];
  assign accessRetryLimit = limit_q[`ARA_ACCESS_MSB:`ARA_ACCESS_LSB];

  // read data for an address
  function automatic logic [7:0] readMux(input logic [5:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `ARA_ADDR_STATE:
        r = {ackWaiting_q ? `ARA_AWAIT_ACK_CODE : coreResult,
             coreState};
      `ARA_ADDR_RETRY_STATUS:
        r = {frameCnt_q, accessCnt_q, 1'b0};
      `ARA_ADDR_LIMIT_CTRL: r = limit_q;
      `ARA_ADDR_SEED_LOW:   r = seedLow_q;
      `ARA_ADDR_SEED_HIGH:  r = {5'h00, seedHigh_q};
      default:              r = 8'h00;
    endcase
    return r;
  endfunction : readMux

  // serial port and register next values
  always_comb begin
    bitCnt_d      = bitCnt_q;
    rxShift_d     = rxShift_q;
    txShift_d     = txShift_q;
    addr_d        = addr_q;
    isWrite_d     = isWrite_q;
    miso_d        = spiMiso_q;
    misoOe_d      = 1'b1;
    doWrite       = 1'b0;
    limit_d       = limit_q;
    seedLow_d     = seedLow_q;
    seedHigh_d    = seedHigh_q;
    frameCnt_d    = frameCnt_q;
    accessCnt_d   = accessCnt_q;
    backoffSeed_d = backoffSeed_q;
    if (csnS) begin
      bitCnt_d  = 5'h00;
      miso_d    = 1'b0;
      misoOe_d  = 1'b0;
      txShift_d = 8'h00;
    end else begin
      if (sclkRise && bitCnt_q < `ARA_FRAME_BITS) begin
        rxShift_d = rxNext;
        bitCnt_d  = bitCnt_q + 5'h01;
        if (bitCnt_q == `ARA_CMD_LAST_BIT) begin
          addr_d    = rxNext[5:0];
          isWrite_d = rxNext[`ARA_CMD_WRITE_BIT];
          txShift_d = readMux(rxNext[5:0]);
        end
        if (bitCnt_q == `ARA_DATA_LAST_BIT && isWrite_q) begin
          doWrite = 1'b1;
        end
      end
      if (sclkFall) begin
        miso_d    = txShift_q[7];
        txShift_d = {txShift_q[6:0], 1'b0};
      end
    end
    // host writes; the status register takes none
    if (doWrite) begin
      case (addr_q)
        `ARA_ADDR_LIMIT_CTRL: limit_d    = rxNext;
        `ARA_ADDR_SEED_LOW:   seedLow_d  = rxNext;
        `ARA_ADDR_SEED_HIGH:  seedHigh_d = rxNext[2:0];
        default:              limit_d    = limit_q;
      endcase
    end
    // retry counters follow the transmit sequencer
    if (transactionStart) begin
      frameCnt_d  = 4'h0;
      accessCnt_d = 3'h0;
    end else if (newFrameCycle) begin
      if (frameCnt_q != `ARA_FRAME_CNT_MAX) begin
        frameCnt_d = frameCnt_q + 4'h1;
      end
      accessCnt_d = 3'h0;
    end else if (newBackoffCycle) begin
      if (accessCnt_q != `ARA_ACCESS_CNT_MAX) begin
        accessCnt_d = accessCnt_q + 3'h1;
      end
    end
    immediateTx_d = (limit_d[`ARA_ACCESS_MSB:`ARA_ACCESS_LSB] ==
                     `ARA_ACCESS_IMMEDIATE);
    seedLoad_d = wakeDeep;
    if (wakeDeep) begin
      backoffSeed_d = {seedHigh_q, seedLow_q};
    end
  end

  // slotted acknowledgement hold
  always_comb begin
    ackState_d = ackState_q;
    ackSend_d  = 1'b0;
    case (ackState_q)
      auto_retry_ack_pkg::ACK_IDLE: begin
        if (ackRequest) begin
          if (limit_q[`ARA_SLOT_BIT]) begin
            ackState_d = auto_retry_ack_pkg::ACK_WAIT;
          end else begin
            ackSend_d = 1'b1;
          end
        end
      end
      auto_retry_ack_pkg::ACK_WAIT: begin
        if (trigRise || !limit_q[`ARA_SLOT_BIT]) begin
          ackSend_d  = 1'b1;
          ackState_d = auto_retry_ack_pkg::ACK_IDLE;
        end
      end
      default: ackState_d = auto_retry_ack_pkg::ACK_IDLE;
    endcase
    ackWaiting_d = (ackState_d == auto_retry_ack_pkg::ACK_WAIT);
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev_q    <= 1'b0;
      trigPrev_q    <= 1'b0;
      bitCnt_q      <= 5'h00;
      rxShift_q     <= 8'h00;
      txShift_q     <= 8'h00;
      addr_q        <= 6'h00;
      isWrite_q     <= 1'b0;
      spiMiso_q     <= 1'b0;
      spiMisoOe_q   <= 1'b0;
      limit_q       <= `ARA_LIMIT_CTRL_RST;
      seedLow_q     <= `ARA_SEED_LOW_RST;
      seedHigh_q    <= `ARA_SEED_HIGH_RST;
      frameCnt_q    <= 4'h0;
      accessCnt_q   <= 3'h0;
      immediateTx_q <= 1'b0;
      backoffSeed_q <= {`ARA_SEED_HIGH_RST, `ARA_SEED_LOW_RST};
      seedLoad_q    <= 1'b0;
      ackState_q    <= auto_retry_ack_pkg::ACK_IDLE;
      ackSend_q     <= 1'b0;
      ackWaiting_q  <= 1'b0;
    end else begin
      sclkPrev_q    <= sclkS;
      trigPrev_q    <= trigS;
      bitCnt_q      <= bitCnt_d;
      rxShift_q     <= rxShift_d;
      txShift_q     <= txShift_d;
      addr_q        <= addr_d;
      isWrite_q     <= isWrite_d;
      spiMiso_q     <= miso_d;
      spiMisoOe_q   <= misoOe_d;
      limit_q       <= limit_d;
      seedLow_q     <= seedLow_d;
      seedHigh_q    <= seedHigh_d;
      frameCnt_q    <= frameCnt_d;
      accessCnt_q   <= accessCnt_d;
      immediateTx_q <= immediateTx_d;
      backoffSeed_q <= backoffSeed_d;
      seedLoad_q    <= seedLoad_d;
      ackState_q    <= ackState_d;
      ackSend_q     <= ackSend_d;
      ackWaiting_q  <= ackWaiting_d;
    end
  end

endmodule : auto_retry_ack_control_regs

//--- verilog/auto_retry_ack_pkg.sv
// Purpose: types of the retry and acknowledgement register block
// Assumes: nothing
// Notes:   constants live in auto_retry_ack_cfg.svh
package auto_retry_ack_pkg;

  // slotted acknowledgement hold state
  typedef enum logic {
    ACK_IDLE,
    ACK_WAIT
  } ack_state_t;

endpackage : auto_retry_ack_pkg

//--- verilog/sync_two_ff.sv
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps

module sync_two_ff #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  input  wire logic             clk,    // block clock
  input  wire logic             arst_n, // async reset, active low
  input  wire logic [WIDTH-1:0] d,      // asynchronous inputs
  output logic      [WIDTH-1:0] q       // synchronised outputs
);

  logic [WIDTH-1:0] stage1_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= RST;
      q        <= RST;
    end else begin
      stage1_q <= d;
      q        <= stage1_q;
    end
  end

endmodule : sync_two_ff
